// ---- include/bro_params.svh ----
// Constants for the parallel BCD result output port.
// Assumes a single 125 MHz clock; times are given in milliseconds.
`ifndef BRO_PARAMS_SVH
`define BRO_PARAMS_SVH

// Clock rate in kHz, so that cycles = ms * kHz
`define BRO_CLK_KHZ      125000

// Result layout
`define BRO_DIGITS       5
`define BRO_BCD_W        20
`define BRO_CNT_W        24

// Port timing in ms
`define BRO_SETUP_MS     30
`define BRO_STROBE_MS    40
`define BRO_TAIL_MS      16
`define BRO_PERIOD_MS    64
`define BRO_REARM_MS     20

// Reset values
`define BRO_BCD_RST      20'h00000
`define BRO_CNT_RST      24'h000000

`endif

// ---- include/bro_pkg.sv ----
// Types shared by the BCD result output port and its phase timer.
// Widths come from bro_params.svh.
`include "bro_params.svh"

package bro_pkg;

  // Output sequence phases
  typedef enum logic [2:0] {
    BRO_IDLE,
    BRO_SETUP,
    BRO_STROBE,
    BRO_GAP,
    BRO_TAIL
  } bro_state_e;

  // Phase counter and BCD word
  typedef logic [`BRO_CNT_W-1:0] bro_cnt_t;
  typedef logic [`BRO_BCD_W-1:0] bro_bcd_t;

endpackage

// ---- src/bro_output_port.sv ----
// Parallel BCD result output port: request-driven single and continuous
// output of the measurement with a data-valid strobe and a hold input.
// Assumes request and hold are synchronous to clk and the measurement
// inputs carry the present result, stable while the producer updates it.
//
// Notes on behaviour
// - A BCD result is only put on the data lines in answer to a read request.
// - A request edge places data at once and raises the strobe 30 ms later.
// - In a single read the strobe stays high for 40 ms and then falls.
// - In a single read the data lines go off 16 ms after the strobe falls.
// - A held request repeats the sequence with a fresh result every 64 ms.
// - Hold keeps the earlier result in place of the later one, never dropping lines low.
// - Request and hold inputs are active low.
`timescale 1ns/1ps
`include "bro_params.svh"

module bro_output_port #(
  parameter int unsigned T_SETUP_CYC  = `BRO_SETUP_MS * `BRO_CLK_KHZ,
  parameter int unsigned T_STROBE_CYC = `BRO_STROBE_MS * `BRO_CLK_KHZ,
  parameter int unsigned T_TAIL_CYC   = `BRO_TAIL_MS * `BRO_CLK_KHZ,
  parameter int unsigned T_GAP_CYC    = (`BRO_PERIOD_MS - `BRO_STROBE_MS) * `BRO_CLK_KHZ
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Control contacts from the reader
  input  wire logic              reqN,
  input  wire logic              holdN,
  // Present measurement
  input  wire bro_pkg::bro_bcd_t measBcd,
  input  wire logic              measNeg,
  input  wire logic              measOver,
  // BCD result lines
  output bro_pkg::bro_bcd_t      bcdOut,
  output logic                   polarityOut,
  output logic                   overOut,
  output logic                   dataOn,
  output logic                   dataValid
);

  typedef struct packed {
    bro_pkg::bro_state_e state;
    logic                reqPrev;
    bro_pkg::bro_bcd_t   bcd;
    logic                neg;
    logic                over;
    logic                on;
    logic                valid;
  } bro_port_s;

  logic              rstMeta;
  logic              rstSync;
  bro_port_s         port_reg;
  bro_port_s         port_next;
  logic              reqOn;
  logic              holdOn;
  logic              tmrStart;
  bro_pkg::bro_cnt_t tmrLimit;
  logic              tmrDone;

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Contacts closed to common read as asserted
  assign reqOn  = ~reqN;
  assign holdOn = ~holdN;

  // Phase timer shared by all phases
  bro_phase_timer u_timer (
    .clk   (clk),
    .rstN  (rstSync),
    .start (tmrStart),
    .limit (tmrLimit),
    .done  (tmrDone),
    .busy  ()
  );

  // Output sequence
  always_comb
  begin
    port_next = port_reg;
    tmrStart  = 1'b0;
    tmrLimit  = `BRO_CNT_RST;
    port_next.reqPrev = reqOn;
    unique case (port_reg.state)
      bro_pkg::BRO_IDLE:
      begin
        // Only a new request edge puts a result out
        if (reqOn && !port_reg.reqPrev)
        begin
          port_next.bcd   = measBcd;
          port_next.neg   = measNeg;
          port_next.over  = measOver;
          port_next.on    = 1'b1;
          port_next.state = bro_pkg::BRO_SETUP;
          tmrStart = 1'b1;
          tmrLimit = `BRO_CNT_W'(T_SETUP_CYC);
        end
      end
      bro_pkg::BRO_SETUP:
      begin
        // Data settled, raise the strobe
        if (tmrDone)
        begin
          port_next.valid = 1'b1;
          port_next.state = bro_pkg::BRO_STROBE;
          tmrStart = 1'b1;
          tmrLimit = `BRO_CNT_W'(T_STROBE_CYC);
        end
      end
      bro_pkg::BRO_STROBE:
      begin
        // Data frozen while the strobe is high
        if (tmrDone)
        begin
          port_next.valid = 1'b0;
          tmrStart = 1'b1;
          if (reqOn)
          begin
            port_next.state = bro_pkg::BRO_GAP;
            tmrLimit = `BRO_CNT_W'(T_GAP_CYC);
          end
          else
          begin
            port_next.state = bro_pkg::BRO_TAIL;
            tmrLimit = `BRO_CNT_W'(T_TAIL_CYC);
          end
        end
      end
      bro_pkg::BRO_GAP:
      begin
        // Lines keep the last result until the next strobe
        if (tmrDone)
        begin
          tmrStart = 1'b1;
          if (reqOn)
          begin
            // Under hold the earlier result stays, never a low gap
            if (!holdOn)
            begin
              port_next.bcd  = measBcd;
              port_next.neg  = measNeg;
              port_next.over = measOver;
            end
            port_next.valid = 1'b1;
            port_next.state = bro_pkg::BRO_STROBE;
            tmrLimit = `BRO_CNT_W'(T_STROBE_CYC);
          end
          else
          begin
            port_next.state = bro_pkg::BRO_TAIL;
            tmrLimit = `BRO_CNT_W'(T_TAIL_CYC);
          end
        end
      end
      bro_pkg::BRO_TAIL:
      begin
        // Release the lines to their off state
        if (tmrDone)
        begin
          port_next.bcd   = `BRO_BCD_RST;
          port_next.neg   = 1'b0;
          port_next.over  = 1'b0;
          port_next.on    = 1'b0;
          port_next.state = bro_pkg::BRO_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      port_reg <= '{state: bro_pkg::BRO_IDLE, reqPrev: 1'b0, bcd: `BRO_BCD_RST,
                    neg: 1'b0, over: 1'b0, on: 1'b0, valid: 1'b0};
    end
    else
    begin
      port_reg <= port_next;
    end
  end

  // Outputs straight from flops
  assign bcdOut      = port_reg.bcd;
  assign polarityOut = port_reg.neg;
  assign overOut     = port_reg.over;
  assign dataOn      = port_reg.on;
  assign dataValid   = port_reg.valid;

endmodule

// ---- src/bro_phase_timer.sv ----
// One-shot down counter timing each phase of the output sequence.
// Assumes start is a one-cycle pulse and limit is at least 2.
`timescale 1ns/1ps
`include "bro_params.svh"

module bro_phase_timer (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Control
  input  wire logic             start,
  input  wire bro_pkg::bro_cnt_t limit,
  // Status
  output logic                  done,
  output logic                  busy
);

  typedef struct packed {
    bro_pkg::bro_cnt_t cnt;
    logic              run;
    logic              done;
  } bro_tmr_s;

  bro_tmr_s tmr_reg;
  bro_tmr_s tmr_next;

  // Reload on start, count down, pulse done at the end
  always_comb
  begin
    tmr_next = tmr_reg;
    tmr_next.done = 1'b0;
    if (start)
    begin
      tmr_next.cnt = limit - `BRO_CNT_W'(1); // User acts on done limit edges on
      tmr_next.run = 1'b1;
    end
    else if (tmr_reg.run)
    begin
      if (tmr_reg.cnt == `BRO_CNT_W'(1))
      begin
        tmr_next.run  = 1'b0;
        tmr_next.done = 1'b1;
      end
      else
      begin
        tmr_next.cnt = tmr_reg.cnt - `BRO_CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      tmr_reg <= '{cnt: `BRO_CNT_RST, run: 1'b0, done: 1'b0};
    end
    else
    begin
      tmr_reg <= tmr_next;
    end
  end

  // Outputs from flops
  assign done = tmr_reg.done;
  assign busy = tmr_reg.run;

endmodule

// ---- test/bro_output_port_bench.sv ----
// Testbench for the BCD result output port with a reader model.
// Assumes shortened phase counts set at the instance.
`timescale 1ns/1ps
`include "bro_params.svh"

module bro_output_port_bench;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              holdN = 1'b1;
  logic              measNeg = 1'b0;
  logic              measOver = 1'b0;
  logic              nines = 1'b0;
  bro_pkg::bro_bcd_t measBcd = 20'h00000;
  bro_pkg::bro_bcd_t bcdOut;
  logic              reqN, polarityOut, overOut, dataOn, dataValid;
  logic [21:0]       want[$];
  int                errors = 0;
  int                checked = 0;

  // 8 ns clock
  always #4 clk = ~clk;

  // Port under test with short phases
  bro_output_port #(.T_SETUP_CYC(20), .T_STROBE_CYC(30), .T_TAIL_CYC(10), .T_GAP_CYC(15))
  bro_output_port_inst (.clk(clk), .nrst(nrst), .reqN(reqN), .holdN(holdN),
    .measBcd(measBcd), .measNeg(measNeg), .measOver(measOver), .bcdOut(bcdOut),
    .polarityOut(polarityOut), .overOut(overOut), .dataOn(dataOn), .dataValid(dataValid));

  // Reader on the far side
  bro_reader_model #(.REARM(14)) bro_reader_model_inst (.clk(clk), .dataValid(dataValid),
    .bcdOut(bcdOut), .polarityOut(polarityOut), .overOut(overOut), .reqN(reqN));

  // Expected word for a measurement
  function automatic logic [21:0] expWord(input bro_pkg::bro_bcd_t b, input logic n,
                                          input logic o);
    return {o, n, b};
  endfunction

  // Compare and count
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // New measurement, random digits or all nines
  task automatic newMeas(output logic [21:0] w);
    for (int d = 0; d < `BRO_DIGITS; d++)
      measBcd[4*d +: 4] = 4'($urandom % 10);
    if (nines)
      measBcd = 20'h99999;
    {measOver, measNeg} = 2'($urandom);
    w = expWord(measBcd, measNeg, measOver);
  endtask

  // One request for n results, hold on the first change-over if asked
  task automatic run(input int n, input logic useHold);
    logic [21:0] last;
    logic [21:0] nxt;
    #1 newMeas(last);
    fork
      bro_reader_model_inst.read(n);
      for (int i = 0; i < n; i++)
      begin
        @(posedge clk iff dataValid);
        want.push_back(last);
        #1 holdN = !(useHold && i == 0);
        newMeas(nxt);
        if (holdN)
          last = nxt;
        @(posedge clk iff !dataValid);
      end
    join
    check({overOut, polarityOut, bcdOut}, 22'h000000);
    check({20'h00000, dataOn, dataValid}, 22'h000000);
    check(22'(bro_reader_model_inst.got.size()), 22'(n));
    while (want.size() > 0)
      check(bro_reader_model_inst.got.pop_front(), want.pop_front());
  endtask

  // Print counts and verdict, then stop
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h1D45));
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    run(1, 1'b0);
    nines = 1'b1;
    run(2, 1'b0);
    nines = 1'b0;
    run(3, 1'b1);
    for (int k = 0; k < 6; k++)
      run(1 + int'($urandom % 3), 1'($urandom));
    give_verdict();
  end

  // Watchdog
  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule

// ---- test/bro_output_port_monitor.sv ----
// Checker for the BCD result output port, watching its ports only.
// Assumes the phase parameters are handed on from the bound instance.
`timescale 1ns/1ps

module bro_output_port_checker #(
  parameter int T_SETUP_CYC  = 20,
  parameter int T_STROBE_CYC = 30,
  parameter int T_TAIL_CYC   = 10,
  parameter int T_GAP_CYC    = 15
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // Port inputs
  input wire logic              reqN,
  input wire logic              holdN,
  input wire bro_pkg::bro_bcd_t measBcd,
  input wire logic              measNeg,
  input wire logic              measOver,
  // Port outputs
  input wire bro_pkg::bro_bcd_t bcdOut,
  input wire logic              polarityOut,
  input wire logic              overOut,
  input wire logic              dataOn,
  input wire logic              dataValid
);
  // Last cycle of each phase; a phase lasts exactly its count
  localparam int SETUP_LAST  = T_SETUP_CYC - 1;
  localparam int STROBE_LAST = T_STROBE_CYC - 1;
  localparam int TAIL_LAST   = T_TAIL_CYC - 1;
  localparam int GAP_LAST    = T_GAP_CYC - 1;

  logic [21:0] word;
  logic [21:0] measWord;

  // Result word on the lines and the word on offer
  assign word     = {overOut, polarityOut, bcdOut};
  assign measWord = {measOver, measNeg, measBcd};

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_load;
    $rose(dataOn) |-> !$past(reqN) && word == $past(measWord);
  endproperty
  a_load: assert property (p_load)
    else $error("result not taken on request");
  property p_off;
    !dataOn |-> word == 22'h000000;
  endproperty
  a_off: assert property (p_off)
    else $error("lines not off");
  property p_setup;
    $rose(dataOn) |-> (!dataValid throughout ##SETUP_LAST 1) ##1 dataValid;
  endproperty
  a_setup: assert property (p_setup)
    else $error("strobe setup wrong");
  property p_strobe;
    $rose(dataValid) |-> (dataValid throughout ##STROBE_LAST 1) ##1 !dataValid;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe length wrong");
  property p_tail;
    $fell(dataValid) && $past(reqN) |-> (dataOn throughout ##TAIL_LAST 1) ##1 !dataOn;
  endproperty
  a_tail: assert property (p_tail)
    else $error("tail length wrong");
  property p_period;
    $fell(dataValid) && !$past(reqN) |->
      ((dataOn && !dataValid) throughout ##GAP_LAST 1) ##1 (dataValid || $past(reqN));
  endproperty
  a_period: assert property (p_period)
    else $error("repeat period wrong");
  property p_stable;
    dataValid ##1 dataValid |-> $stable(word);
  endproperty
  a_stable: assert property (p_stable)
    else $error("lines moved under strobe");
  property p_hold;
    $rose(dataValid) && !$past(holdN) |-> $stable(word);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold not kept");
endmodule

bind bro_output_port bro_output_port_checker #(
  .T_SETUP_CYC(T_SETUP_CYC), .T_STROBE_CYC(T_STROBE_CYC),
  .T_TAIL_CYC(T_TAIL_CYC), .T_GAP_CYC(T_GAP_CYC)
) bro_output_port_checker_inst (
  .clk(clk), .nrst(nrst), .reqN(reqN), .holdN(holdN), .measBcd(measBcd),
  .measNeg(measNeg), .measOver(measOver), .bcdOut(bcdOut), .polarityOut(polarityOut),
  .overOut(overOut), .dataOn(dataOn), .dataValid(dataValid)
);

// ---- test/bro_reader_model.sv ----
// Reader model: pulls the request contact low and captures on the strobe.
// Assumes the port answers each request with a strobed result.
`timescale 1ns/1ps

module bro_reader_model #(
  parameter int REARM = 14
) (
  // Clock and result lines
  input  wire logic              clk,
  input  wire logic              dataValid,
  input  wire bro_pkg::bro_bcd_t bcdOut,
  input  wire logic              polarityOut,
  input  wire logic              overOut,
  // Request contact, active low
  output logic                   reqN
);
  logic [21:0] got[$];

  // Contact open when idle
  initial reqN = 1'b1;

  // Ask for n results, letting go on the last strobe
  task automatic read(input int n);
    @(posedge clk) #1 reqN = 1'b0;
    for (int i = 1; i <= n; i++)
    begin
      @(posedge clk iff dataValid);
      got.push_back({overOut, polarityOut, bcdOut});
      if (i == n)
        #1 reqN = 1'b1;
      @(posedge clk iff !dataValid);
    end
    repeat (REARM) @(posedge clk);
  endtask
endmodule
